// >>> bench/odw_host.sv
// Host serial port model driving sync, shift clock and data pins
`timescale 1ns/1ps
module odw_host (
   // Framing style
   input wire logic framing_mode,
   // Link pins
   output logic frame_sync,
   output logic shift_clk,
   output logic serial_in
);
   initial begin
      frame_sync = 1'b1;
      shift_clk = 1'b1;
      serial_in = 1'b0;
   end
   // In microcontroller framing fewer than 16 bits aborts; lag runs from last shift clock rise to sync rise
   task automatic send(input logic [15:0] w, input int n, input int lag);
      if (!framing_mode) begin
         shift_clk = 1'b0;
         #40 shift_clk = 1'b1;
         #40;
      end
      frame_sync = 1'b0;
      #40;
      for (int i = 15; i >= 16 - n; i--) begin
         serial_in = w[i];
         #40 shift_clk = 1'b0;
         if (!framing_mode) frame_sync = 1'b1;
         #40 shift_clk = 1'b1;
      end
      #(lag) frame_sync = 1'b1;
      // Released data must not look like a held bit
      serial_in = ~serial_in;
      #120;
   endtask : send
endmodule : odw_host

// >>> bench/odw_serial_port_assertions.sv
// Port checker of the octal DAC serial write port
`timescale 1ns/1ps
module odw_chk (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Link pins
   input wire logic frame_sync,
   input wire logic shift_clk,
   input wire logic latch_load_strobe_b,
   input wire logic framing_mode,
   // Outputs
   input wire logic chain_out,
   input wire logic chain_out_en,
   input wire logic [odw_pkg::ODW_CHANNELS-1:0][odw_pkg::ODW_CODE_BITS-1:0]
      dac_code,
   input wire odw_pkg::odw_code_t preset_code,
   input wire logic power_down_all,
   input wire logic [odw_pkg::ODW_PAIRS-1:0] pair_power_down,
   input wire logic [odw_pkg::ODW_PAIRS-1:0] pair_fast
);
   import odw_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   chk_reset_clear:
   assert property (disable iff (1'b0) !rst_b |-> dac_code == '0
      && preset_code == '0 && !chain_out_en && !power_down_all)
      else $error("outputs not clear in reset");
   chk_reset_hold:
   assert property ($rose(rst_b) |=> (dac_code == '0 && pair_fast == '0)[*2])
      else $error("outputs moved after reset");
   chk_latch_hold:
   assert property (latch_load_strobe_b[*5] |=> $stable(dac_code))
      else $error("latch moved with strobe high");
   chk_chain_off:
   assert property (!chain_out_en |-> !chain_out)
      else $error("chain output active while disabled");
   chk_chain_step:
   assert property (chain_out_en && $past(chain_out_en, 2)
      && $changed(chain_out) |-> !$past(shift_clk, 2))
      else $error("chain moved without shift fall");
   chk_dsp_commit:
   assert property (!framing_mode && $changed(preset_code)
      |-> !$past(shift_clk, 2)) else $error("word stored away from a fall");
   chk_uc_commit:
   assert property (framing_mode && $changed(preset_code)
      |-> $past(frame_sync, 2)) else $error("word stored before sync rise");
   chk_uc_stable:
   assert property ((framing_mode && !frame_sync)[*4] |=> $stable(preset_code)
      && $stable(pair_fast) && $stable(power_down_all)
      && $stable(pair_power_down)) else $error("update inside frame");
endmodule : odw_chk

bind odw_serial_port odw_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
   .frame_sync(frame_sync), .shift_clk(shift_clk),
   .latch_load_strobe_b(latch_load_strobe_b), .framing_mode(framing_mode),
   .chain_out(chain_out), .chain_out_en(chain_out_en), .dac_code(dac_code),
   .preset_code(preset_code), .power_down_all(power_down_all),
   .pair_power_down(pair_power_down), .pair_fast(pair_fast));

// >>> bench/odw_serial_port_test.sv
// Self-checking bench of the octal DAC serial write port
`timescale 1ns/1ps
module odw_serial_port_test;
   import odw_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b1;
   logic latch_load_strobe_b = 1'b1;
   logic framing_mode = 1'b0;
   logic frame_sync, shift_clk, serial_in, chain_out, chain_out_en;
   logic [ODW_CHANNELS-1:0][ODW_CODE_BITS-1:0] dac_code;
   odw_code_t preset_code;
   logic power_down_all;
   logic [ODW_PAIRS-1:0] pair_power_down, pair_fast;
   int err_count = 0;
   int n_tests = 0;
   logic [11:0] hold_m [8] = '{default: '0};
   logic [11:0] lat_m [8] = '{default: '0};
   logic [11:0] ctl0_m = '0, ctl1_m = '0, pre_m = '0;
   logic [31:0] rng = 32'h5375d60b;
   logic bit_q [$];
   bit chain_on = 1'b0;

   always #5 clk_sys = ~clk_sys;
   odw_host host (.framing_mode(framing_mode), .frame_sync(frame_sync),
      .shift_clk(shift_clk), .serial_in(serial_in));
   odw_serial_port dut (.clk_sys(clk_sys), .rst_b(rst_b),
      .frame_sync(frame_sync), .shift_clk(shift_clk), .serial_in(serial_in),
      .latch_load_strobe_b(latch_load_strobe_b), .framing_mode(framing_mode),
      .chain_out(chain_out), .chain_out_en(chain_out_en),
      .dac_code(dac_code), .preset_code(preset_code),
      .power_down_all(power_down_all), .pair_power_down(pair_power_down),
      .pair_fast(pair_fast));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic cmp_code(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_code
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_code({11'h0, got}, {11'h0, exp});
   endtask : cmp_bit
   task automatic check_all();
      for (int c = 0; c < 8; c++) cmp_code(dac_code[c], lat_m[c]);
      cmp_code(preset_code, pre_m);
      cmp_code({4'h0, pair_power_down, pair_fast}, {4'h0, ctl1_m[7:0]});
      cmp_bit(power_down_all, ctl0_m[4]);
      cmp_bit(chain_out_en, ctl0_m[3]);
   endtask : check_all
   task automatic model(input logic [15:0] w);
      logic [11:0] d;
      d = w[11:0] & ODW_CODE_MASK;
      if (ctl0_m[0]) d = d ^ 12'h800;
      case (w[15:12])
         4'h8: ctl0_m = w[11:0];
         4'h9: ctl1_m = w[11:0];
         4'ha: pre_m = d;
         4'hb: ;
         default: begin
            if (w[15]) begin
               hold_m[2 * w[13:12]] = d;
               hold_m[2 * w[13:12] + 1] = ~d & ODW_CODE_MASK;
            end else hold_m[w[14:12]] = d;
         end
      endcase
      if (!latch_load_strobe_b) lat_m = hold_m;
   endtask : model
   task automatic wr(input logic [15:0] w, input int n);
      @(negedge clk_sys);
      host.send(w, n, 80);
      if (n == 16) model(w);
      repeat (10) @(negedge clk_sys);
      check_all();
   endtask : wr
   task automatic load();
      @(negedge clk_sys) latch_load_strobe_b = 1'b0;
      repeat (6) @(negedge clk_sys);
      latch_load_strobe_b = 1'b1;
      lat_m = hold_m;
      repeat (6) @(negedge clk_sys);
      check_all();
   endtask : load
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test

   // Chain value seen at a fall is the one left by the previous fall
   always @(negedge shift_clk) begin
      if (chain_on && bit_q.size() >= 17)
         cmp_bit(chain_out, bit_q[bit_q.size() - 17]);
      else if (!ctl0_m[3]) cmp_bit(chain_out, 1'b0);
      bit_q.push_back(serial_in);
   end

   initial begin
      #400000;
      err_count++;
      finish_test();
   end

   initial begin
      // Pulled low after time zero so the asynchronous reset sees an edge
      #1 rst_b = 1'b0;
      repeat (3) @(negedge clk_sys);
      rst_b = 1'b1;
      repeat (8) @(negedge clk_sys);
      check_all();
      $display("reset test done");
      for (int m = 0; m < 2; m++) begin
         framing_mode = m[0];
         latch_load_strobe_b = ~m[0];
         for (int a = 0; a < 16; a++) begin
            rng = xs(rng);
            wr({a[3:0], rng[11:0]}, 16);
         end
         load();
         $display("write test done");
      end
      latch_load_strobe_b = 1'b0;
      @(negedge clk_sys);
      fork
         host.send(16'ha5a5, 16, 400);
         #1500 check_all();
      join
      model(16'ha5a5);
      repeat (10) @(negedge clk_sys);
      check_all();
      wr(16'h3123, 9);
      wr(16'h3456, 16);
      $display("framing test done");
      wr(16'h8008, 16);
      // Falls before enabling are unknown to the queue
      chain_on = 1'b1;
      bit_q.delete();
      for (int i = 0; i < 3; i++) begin
         rng = xs(rng);
         wr({1'b0, rng[14:0]}, 16);
      end
      chain_on = 1'b0;
      wr(16'h8001, 16);
      wr(16'hc7ff, 16);
      $display("chain test done");
      // Reset in mid-run must clear every store, two's complement mode too
      @(negedge clk_sys) rst_b = 1'b0;
      repeat (3) @(negedge clk_sys);
      rst_b = 1'b1;
      hold_m = '{default: '0};
      lat_m = '{default: '0};
      ctl0_m = '0;
      ctl1_m = '0;
      pre_m = '0;
      repeat (8) @(negedge clk_sys);
      check_all();
      wr(16'h2abc, 16);
      $display("second reset test done");
      finish_test();
   end
endmodule : odw_serial_port_test

// >>> rtl/odw_chain_delay.sv
// Sixteen-edge delay line for the daisy-chain output
`timescale 1ns/1ps
module odw_chain_delay (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_sync_b,
   // Sample strobe and data
   input wire logic sample,
   input wire logic bit_in,
   input wire logic enable,
   // Chain pin
   output logic chain_out,
   output logic chain_out_en
);
   import odw_pkg::*;

   logic [ODW_WORD_BITS-1:0] line_reg;
   logic [ODW_WORD_BITS-1:0] line_next;
   logic out_reg;
   logic out_next;
   logic en_reg;
   logic en_next;

   always_comb begin
      line_next = line_reg;
      out_next = out_reg;
      // Enable is delayed with the data so both pins drop on one edge
      en_next = enable;
      if (sample) begin
         // Taken before the shift, so the bit is sixteen edges old
         out_next = line_reg[ODW_WORD_BITS-1]; // R4
         line_next = {line_reg[ODW_WORD_BITS-2:0], bit_in};
      end
      // Line keeps running while disabled so it is valid on enable
      if (!enable) begin
         out_next = 1'b0; // R16
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         line_reg <= ODW_CHAIN_RST;
         out_reg <= 1'b0;
         en_reg <= 1'b0;
      end else begin
         line_reg <= line_next;
         out_reg <= out_next;
         en_reg <= en_next;
      end
   end

   assign chain_out = out_reg;
   assign chain_out_en = en_reg; // R16
endmodule : odw_chain_delay

// >>> rtl/odw_pkg.sv
// Shared constants and types of the octal DAC serial write port
package odw_pkg;
   // Word layout
   localparam int ODW_WORD_BITS = 16;
   localparam int ODW_CODE_BITS = 12;
   localparam int ODW_ADDR_MSB = 15;
   localparam int ODW_ADDR_LSB = 12;
   localparam int ODW_CHANNELS = 8;
   localparam int ODW_PAIRS = 4;
   // Converter resolution: 12, 10 or 8; lower bits are ignored
   localparam int ODW_RES_BITS = 12;
   localparam logic [11:0] ODW_CODE_MASK =
      12'hfff << (ODW_CODE_BITS - ODW_RES_BITS);
   localparam logic [11:0] ODW_TWOS_FLIP = 12'h800;
   // Address decode
   localparam logic [3:0] ODW_ADDR_CTRL0 = 4'h8;
   localparam logic [3:0] ODW_ADDR_CTRL1 = 4'h9;
   localparam logic [3:0] ODW_ADDR_PRESET = 4'ha;
   localparam logic [3:0] ODW_ADDR_RSVD = 4'hb;
   localparam logic [1:0] ODW_PAIR_TAG = 2'h3;
   // Control zero fields
   localparam int ODW_C0_PD = 4;
   localparam int ODW_C0_DO = 3;
   localparam int ODW_C0_IM = 0;
   // Control one fields
   localparam int ODW_C1_SPEED_LSB = 0;
   localparam int ODW_C1_PWR_LSB = 4;
   // Reset values
   localparam logic [11:0] ODW_CODE_RST = 12'h000;
   localparam logic [15:0] ODW_WORD_RST = 16'h0000;
   localparam logic [3:0] ODW_CNT_RST = 4'h0;
   localparam logic [3:0] ODW_CNT_LAST = 4'hf;
   localparam logic [15:0] ODW_CHAIN_RST = 16'h0000;
   // Synchroniser lanes
   localparam int ODW_PIN_COUNT = 5;
   localparam int ODW_PIN_FS = 0;
   localparam int ODW_PIN_SCLK = 1;
   localparam int ODW_PIN_DIN = 2;
   localparam int ODW_PIN_LOAD = 3;
   localparam int ODW_PIN_MODE = 4;
   localparam logic [4:0] ODW_PIN_RST = 5'h00;

   typedef logic [ODW_CODE_BITS-1:0] odw_code_t;
   typedef enum logic [2:0] {
      ODW_IDLE = 3'b001,
      ODW_SHIFT = 3'b010,
      ODW_HOLD = 3'b100
   } odw_state_t;
endpackage : odw_pkg

// >>> rtl/odw_serial_port.sv
// Serial write port of an eight-channel DAC: shifter, decode, latches
// Function
// R1: Frame sync fall starts capture, MSB first, one bit per shift clock fall.
// R2: After sixteen bits the word goes to the holding register it addresses.
// R3: Holding registers pass to DAC latches only while load strobe is low.
// R4: Chain output repeats sampled input sixteen shift clock edges later.
// R5: Reset clears holding registers, latches and control state to zero.
// R6: Mode pin low selects DSP framing, high selects microcontroller framing.
// R7: Microcontroller framing: frame sync rising before bit sixteen cancels.
// R8: Microcontroller framing: update only after sync rises after bit 16.
// R9: DSP framing: frame sync may rise early; all sixteen bits still captured.
// R10: DSP framing: host gives an extra shift clock fall before frame sync.
// R11: Microcontroller framing: extra fall optional, not just after sync rise.
// R12: Data field is a 12-bit code; smaller variants drop low bits.
// R13: Top four bits address channels, controls, preset, reserved, pairs.
// R14: The 8-bit variant uses data bits eleven to four only.
// R15: Pair write loads first channel with code, second with complement.
// R16: Chain output only runs while its control zero enable bit is set.
// R17: Cancelled transfer changes nothing; next frame restarts count at zero.
`timescale 1ns/1ps
module odw_serial_port (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Serial link pins
   input wire logic frame_sync,
   input wire logic shift_clk,
   input wire logic serial_in,
   input wire logic latch_load_strobe_b,
   input wire logic framing_mode,
   // Daisy-chain pin
   output logic chain_out,
   output logic chain_out_en,
   // Converter side
   output logic [odw_pkg::ODW_CHANNELS-1:0][odw_pkg::ODW_CODE_BITS-1:0]
      dac_code,
   output odw_pkg::odw_code_t preset_code,
   output logic power_down_all,
   output logic [odw_pkg::ODW_PAIRS-1:0] pair_power_down,
   output logic [odw_pkg::ODW_PAIRS-1:0] pair_fast
);
   import odw_pkg::*;

   // Drop the bits that this resolution does not decode
   function automatic odw_code_t odw_trim(input odw_code_t code);
      odw_trim = code & ODW_CODE_MASK; // R12 R14
   endfunction : odw_trim

   // Two's complement input is turned into straight binary
   function automatic odw_code_t odw_to_binary(input odw_code_t code,
                                               input logic twos);
      odw_to_binary = odw_trim(twos ? (code ^ ODW_TWOS_FLIP) : code);
   endfunction : odw_to_binary

   // Channel of one half of a two-channel register
   function automatic logic [2:0] odw_pair_ch(input logic [1:0] pair,
                                              input logic second);
      odw_pair_ch = {pair, second};
   endfunction : odw_pair_ch

   // Reset release
   logic [1:0] rst_pipe_reg;
   logic [1:0] rst_pipe_next;
   logic rst_sync_b;

   // Asserts at once, releases on an edge so all flops leave reset together
   always_comb begin
      rst_pipe_next = {rst_pipe_reg[0], 1'b1};
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_pipe_reg <= 2'b00;
      end else begin
         rst_pipe_reg <= rst_pipe_next;
      end
   end

   assign rst_sync_b = rst_pipe_reg[1];

   // Pin synchronisers
   logic [ODW_PIN_COUNT-1:0] pins_raw;
   logic [ODW_PIN_COUNT-1:0] pins_s;
   logic fs_s;
   logic sclk_s;
   logic din_s;
   logic load_s_b;
   logic mode_uc;

   assign pins_raw[ODW_PIN_FS] = frame_sync;
   assign pins_raw[ODW_PIN_SCLK] = shift_clk;
   assign pins_raw[ODW_PIN_DIN] = serial_in;
   assign pins_raw[ODW_PIN_LOAD] = latch_load_strobe_b;
   assign pins_raw[ODW_PIN_MODE] = framing_mode;

   odw_sync u_sync (
      .clk_sys(clk_sys),
      .rst_sync_b(rst_sync_b),
      .pins_raw(pins_raw),
      .pins_sync(pins_s)
   );

   assign fs_s = pins_s[ODW_PIN_FS];
   assign sclk_s = pins_s[ODW_PIN_SCLK];
   assign din_s = pins_s[ODW_PIN_DIN];
   assign load_s_b = pins_s[ODW_PIN_LOAD];
   // Mode is sampled like the rest; it should only change between frames
   // An open mode pin must be pulled low on the board
   assign mode_uc = pins_s[ODW_PIN_MODE]; // R6

   // Edge detection on the synchronised copies
   logic fs_prev_reg;
   logic fs_prev_next;
   logic sclk_prev_reg;
   logic sclk_prev_next;
   logic fs_fall;
   logic sclk_fall;

   always_comb begin
      fs_prev_next = fs_s;
      sclk_prev_next = sclk_s;
   end

   // Cleared low: a pin copy rising after reset can never look like a fall
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         fs_prev_reg <= 1'b0;
         sclk_prev_reg <= 1'b0;
      end else begin
         fs_prev_reg <= fs_prev_next;
         sclk_prev_reg <= sclk_prev_next;
      end
   end

   assign fs_fall = fs_prev_reg & ~fs_s;
   assign sclk_fall = sclk_prev_reg & ~sclk_s;

   // Frame sequencer
   odw_state_t state_reg;
   odw_state_t state_next;
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic [ODW_WORD_BITS-1:0] shift_reg;
   logic [ODW_WORD_BITS-1:0] shift_next;
   // Commit is combinational; the stores land on the edge that follows
   logic commit;
   logic [ODW_WORD_BITS-1:0] commit_word;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      commit = 1'b0;
      commit_word = shift_reg;
      unique case (state_reg)
         ODW_IDLE: begin
            // A shift clock fall seen while idle is the lead-in edge
            if (fs_fall) begin // R1 R10 R11
               state_next = ODW_SHIFT;
               cnt_next = ODW_CNT_RST; // R17
            end
         end
         ODW_SHIFT: begin
            if (mode_uc && fs_s) begin
               // Early rise: drop the partial word untouched
               state_next = ODW_IDLE; // R7 R17
            end else if (sclk_fall) begin
               shift_next = {shift_reg[ODW_WORD_BITS-2:0], din_s}; // R1
               cnt_next = cnt_reg + 4'h1;
               if (cnt_reg == ODW_CNT_LAST) begin
                  if (mode_uc) begin
                     state_next = ODW_HOLD; // R8
                  end else begin
                     // Frame sync level is ignored here
                     commit = 1'b1; // R2 R9
                     commit_word = shift_next;
                     state_next = ODW_IDLE;
                  end
               end
            end
         end
         ODW_HOLD: begin
            if (fs_s) begin
               commit = 1'b1; // R8
               state_next = ODW_IDLE;
            end
         end
         default: begin
            state_next = ODW_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state_reg <= ODW_IDLE;
         cnt_reg <= ODW_CNT_RST;
         shift_reg <= ODW_WORD_RST;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
      end
   end

   // Holding registers, control registers and preset
   odw_code_t hold_reg [ODW_CHANNELS];
   odw_code_t hold_next [ODW_CHANNELS];
   odw_code_t ctrl0_reg;
   odw_code_t ctrl0_next;
   odw_code_t ctrl1_reg;
   odw_code_t ctrl1_next;
   odw_code_t preset_reg;
   odw_code_t preset_next;
   logic [3:0] addr;
   odw_code_t raw_data;
   odw_code_t code;

   assign addr = commit_word[ODW_ADDR_MSB:ODW_ADDR_LSB];
   assign raw_data = commit_word[ODW_CODE_BITS-1:0];
   assign code = odw_to_binary(raw_data, ctrl0_reg[ODW_C0_IM]);

   always_comb begin
      hold_next = hold_reg;
      ctrl0_next = ctrl0_reg;
      ctrl1_next = ctrl1_reg;
      preset_next = preset_reg;
      if (commit) begin
         if (!addr[3]) begin
            hold_next[addr[2:0]] = code; // R13
         end else if (addr[3:2] == ODW_PAIR_TAG) begin
            hold_next[odw_pair_ch(addr[1:0], 1'b0)] = code; // R15
            hold_next[odw_pair_ch(addr[1:0], 1'b1)] = odw_trim(~code); // R15
         end else if (addr == ODW_ADDR_CTRL0) begin
            ctrl0_next = raw_data; // R13
         end else if (addr == ODW_ADDR_CTRL1) begin
            ctrl1_next = raw_data;
         end else if (addr == ODW_ADDR_PRESET) begin
            preset_next = code;
         end
         // The reserved address is accepted and discarded
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         for (int i = 0; i < ODW_CHANNELS; i++) begin
            hold_reg[i] <= ODW_CODE_RST; // R5
         end
         ctrl0_reg <= ODW_CODE_RST; // R5
         ctrl1_reg <= ODW_CODE_RST;
         preset_reg <= ODW_CODE_RST;
      end else begin
         hold_reg <= hold_next;
         ctrl0_reg <= ctrl0_next;
         ctrl1_reg <= ctrl1_next;
         preset_reg <= preset_next;
      end
   end

   // DAC latches; a strobe tied low makes them transparent
   odw_code_t latch_reg [ODW_CHANNELS];
   odw_code_t latch_next [ODW_CHANNELS];

   generate
      for (genvar ch = 0; ch < ODW_CHANNELS; ch++) begin : g_latch
         always_comb begin
            latch_next[ch] = latch_reg[ch];
            // Level sensitive, so a strobe held low follows every write
            if (!load_s_b) begin
               latch_next[ch] = hold_reg[ch]; // R3
            end
         end
         always_ff @(posedge clk_sys or negedge rst_sync_b) begin
            if (!rst_sync_b) begin
               latch_reg[ch] <= ODW_CODE_RST; // R5
            end else begin
               latch_reg[ch] <= latch_next[ch];
            end
         end
         assign dac_code[ch] = latch_reg[ch];
      end
   endgenerate

   // Daisy chain
   // Every fall feeds the line, idle ones too, so the delay counts edges
   odw_chain_delay u_chain (
      .clk_sys(clk_sys),
      .rst_sync_b(rst_sync_b),
      .sample(sclk_fall),
      .bit_in(din_s),
      .enable(ctrl0_reg[ODW_C0_DO]),
      .chain_out(chain_out),
      .chain_out_en(chain_out_en)
   );

   // Control outputs
   // Reserved control bits are stored but drive nothing
   assign preset_code = preset_reg;
   assign power_down_all = ctrl0_reg[ODW_C0_PD];
   assign pair_power_down = ctrl1_reg[ODW_C1_PWR_LSB +: ODW_PAIRS];
   assign pair_fast = ctrl1_reg[ODW_C1_SPEED_LSB +: ODW_PAIRS];
endmodule : odw_serial_port

// >>> rtl/odw_sync.sv
// Two-flop synchroniser for pins from outside the system clock domain
`timescale 1ns/1ps
module odw_sync (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_sync_b,
   // Pins in, synchronised copy out
   input wire logic [odw_pkg::ODW_PIN_COUNT-1:0] pins_raw,
   output logic [odw_pkg::ODW_PIN_COUNT-1:0] pins_sync
);
   import odw_pkg::*;

   logic [ODW_PIN_COUNT-1:0] meta_reg;
   logic [ODW_PIN_COUNT-1:0] sync_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         meta_reg <= ODW_PIN_RST;
         sync_reg <= ODW_PIN_RST;
      end else begin
         meta_reg <= pins_raw;
         sync_reg <= meta_reg;
      end
   end

   assign pins_sync = sync_reg;
endmodule : odw_sync
